// *** logic/sar_readout.sv ***
// sar_readout: conversion sequencing and serial readout of a 16-bit sar converter.
// assumes pins arrive asynchronously and are synchronised here; the sar core
// presents its code and range flags on clk_in; the pad resolves output and enable.
`timescale 1ns/10ps
`include "sar_regs.svh"

// Notes on behaviour
// R1: trigger rise samples select: high select, low chain
// R2: select tied to trigger picks chain mode
// R3: host waits max conversion time without busy
// R4: select mode busy if trigger/select low at end
// R5: chain mode busy if serial clock high
// R6: trigger rise with select high starts, tristates
// R7: conversion completes whatever the trigger does
// R8: 3-wire no busy: trigger back high early
// R9: after conversion return to acquisition, power down
// R10: 3-wire: trigger fall shows msb, falls shift
// R11: 3-wire: hi-z at 16th fall or trigger rise
// R12: bits hold across both serial clock edges
// R13: 3-wire busy: host holds trigger low
// R14: busy enabled: drive low at completion; done in select mode only, chain mode does not drive the pin at completion
// R15: 3-wire busy: msb first, hi-z at 17th
// R16: 4-wire: select and trigger low drive low
// R17: 4-wire no busy: select back high early
// R18: 4-wire: select fall shows msb, falls shift
// R19: 4-wire: hi-z at 16th fall or select rise
// R20: 4-wire busy: host holds select low
// R21: 4-wire busy: hi-z at 17th or select rise
// R22: 3-wire busy: hi-z until conversion completes
// R23: straight binary, saturating at range ends
// R24: internal clock times conversion, not serial clock
// R25: conversion timer window is parameterised
// R26: result loads 16-bit shifter, msb first; the code uses a 17-bit shifter with a start-bit slot
module sar_readout #(
  parameter int CODE_W = `SAR_CODE_W,
  parameter int CONV_MIN_NS = `SAR_CONV_MIN_NS,
  parameter int CONV_MAX_NS = `SAR_CONV_MAX_NS,
  parameter int CLK_MHZ = `SAR_CLK_MHZ,
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk_in, // 10 MHz core clock
  input wire logic resetn_in, // synchronous reset, active low
  input wire logic conversion_trigger_in, // trigger pin, asynchronous
  input wire logic serial_select_in, // select pin, asynchronous
  input wire logic serial_clock_in, // serial clock pin, asynchronous
  input wire logic [CODE_W-1:0] sample_code_in, // code from the sar core
  input wire logic over_range_in, // input above full scale
  input wire logic under_range_in, // input below zero
  output logic serial_result_out, // serial data level
  output logic serial_result_oe_out, // high while the pin is driven
  output sar_pkg::sar_mode_t readout_mode_out, // mode chosen at the last start
  output logic busy_enable_out, // busy start bit in use
  output logic converting_out, // conversion phase
  output logic powered_down_out, // acquisition phase, core powered down
  output logic conversion_done_out // one-cycle pulse at completion
);

  import sar_pkg::*;

  // conversion window in core cycles: least time up, longest time down
  localparam int CONV_MIN_RAW = (CONV_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_MAX_RAW = (CONV_MAX_NS * CLK_MHZ) / 1000;
  localparam int CONV_MIN_CYC = (CONV_MIN_RAW < 1) ? 1 : CONV_MIN_RAW;
  localparam int CONV_MAX_CYC = (CONV_MAX_RAW < CONV_MIN_CYC) ? CONV_MIN_CYC : CONV_MAX_RAW;
  localparam int CNT_W = $clog2(CONV_MAX_CYC + 1);
  localparam logic [CNT_W-1:0] CONV_END = CNT_W'(CONV_MAX_CYC - 1);
  localparam int SH_W = CODE_W + 1;

  // pin synchronisation and edge detection
  logic [`SAR_PIN_W-1:0] pins_async;
  logic [`SAR_PIN_W-1:0] pins_sync;
  logic [`SAR_PIN_W-1:0] pins_prev;

  assign pins_async[`SAR_PIN_TRIG] = conversion_trigger_in;
  assign pins_async[`SAR_PIN_SEL] = serial_select_in;
  assign pins_async[`SAR_PIN_SCK] = serial_clock_in;

  sar_sync #(
    .WIDTH(`SAR_PIN_W)
  ) u_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .async_in(pins_async),
    .sync_out(pins_sync)
  );

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pins_prev <= '0;
    end else begin
      pins_prev <= pins_sync;
    end
  end

  wire trig_now = pins_sync[`SAR_PIN_TRIG];
  wire sel_now = pins_sync[`SAR_PIN_SEL];
  wire sck_now = pins_sync[`SAR_PIN_SCK];
  // levels just before an edge stand for the pin levels at that edge
  wire sel_before = pins_prev[`SAR_PIN_SEL];
  wire sck_before = pins_prev[`SAR_PIN_SCK];
  wire trig_rise = trig_now && !pins_prev[`SAR_PIN_TRIG];
  wire sck_fall = !sck_now && sck_before;

  // state
  sar_state_t state;
  sar_state_t next_state;
  sar_mode_t mode;
  logic busy_en;
  logic [CNT_W-1:0] conv_cnt;
  logic [SH_W-1:0] shifter;
  logic [4:0] fall_cnt;
  logic seen_select;

  // result buffer between the sar core and the shifter
  logic buf_in_ready;
  logic buf_out_valid;
  logic [CODE_W-1:0] buf_out_data;
  logic [CODE_W-1:0] code_sat;

  wire in_conv = (state == SAR_ST_CONV);
  wire in_load = (state == SAR_ST_LOAD);
  wire in_read = (state == SAR_ST_READ);
  // conversion restarts the readout; a running conversion ignores the trigger
  wire start_conv = trig_rise && !in_conv; // R7
  wire timer_end = in_conv && (conv_cnt == CONV_END); // R24 R25
  // completion waits for room so no finished result is dropped
  wire conv_done = timer_end && buf_in_ready;
  wire selected = !trig_now || !sel_now;
  wire [4:0] fall_limit = busy_en ? `SAR_FALLS_BUSY : `SAR_FALLS_PLAIN;
  wire read_count_end = in_read && seen_select && sck_fall && (fall_cnt == fall_limit - 5'h01);
  wire read_deselect = in_read && seen_select && !selected;
  wire read_end = read_count_end || read_deselect;
  wire next_busy_sel = !trig_now || !sel_now; // R4
  wire next_busy_chain = sck_before; // R5
  wire next_mode_sel = sel_before; // R1 R2

  // saturation of out-of-range inputs
  assign code_sat = over_range_in ? `SAR_CODE_FULL :
                    under_range_in ? `SAR_CODE_ZERO : sample_code_in; // R23

  sar_buf #(
    .WIDTH(CODE_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .in_valid_in(conv_done),
    .in_ready_out(buf_in_ready),
    .in_data_in(code_sat),
    .out_valid_out(buf_out_valid),
    .out_ready_in(in_load),
    .out_data_out(buf_out_data)
  );

  // state transitions
  always_comb begin
    next_state = state;
    unique case (state)
      SAR_ST_IDLE: begin
        if (start_conv) begin
          next_state = SAR_ST_CONV; // R6
        end
      end
      SAR_ST_CONV: begin
        if (conv_done) begin
          next_state = SAR_ST_LOAD; // R9
        end
      end
      SAR_ST_LOAD: begin
        if (start_conv) begin
          next_state = SAR_ST_CONV;
        end else if (buf_out_valid) begin
          next_state = (mode == SAR_MODE_SELECT) ? SAR_ST_READ : SAR_ST_IDLE;
        end
      end
      SAR_ST_READ: begin
        if (start_conv) begin
          next_state = SAR_ST_CONV; // R11
        end else if (read_end) begin
          next_state = SAR_ST_IDLE; // R11 R15 R19 R21
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state <= SAR_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // mode is taken at the start of each conversion
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      mode <= SAR_MODE_SELECT;
    end else if (start_conv) begin
      mode <= next_mode_sel ? SAR_MODE_SELECT : SAR_MODE_CHAIN; // R1 R2
    end
  end

  // busy start bit: chain decides at the start, select mode at completion
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      busy_en <= 1'b0;
    end else if (start_conv) begin
      busy_en <= next_mode_sel ? 1'b0 : next_busy_chain; // R5
    end else if (conv_done && mode == SAR_MODE_SELECT) begin
      busy_en <= next_busy_sel; // R4
    end
  end

  // conversion timer on the core clock, not the serial clock
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      conv_cnt <= '0;
    end else if (start_conv) begin
      conv_cnt <= '0;
    end else if (in_conv && !timer_end) begin
      conv_cnt <= conv_cnt + 1'b1; // R24 R25
    end
  end

  // shifter: busy readout leads with a low start bit, plain readout with the msb
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      shifter <= '0;
    end else if (in_load && buf_out_valid) begin
      shifter <= busy_en ? {1'b0, buf_out_data} : {buf_out_data, 1'b0}; // R26 R14
    end else if (in_read && seen_select && selected && sck_fall) begin
      shifter <= {shifter[SH_W-2:0], 1'b0}; // R10 R15 R18
    end
  end

  // falling edges counted only while the readout is selected
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      fall_cnt <= 5'h00;
    end else if (!in_read) begin
      fall_cnt <= 5'h00;
    end else if (seen_select && selected && sck_fall) begin
      fall_cnt <= fall_cnt + 5'h01; // R11 R15 R19 R21
    end
  end

  // plain readout waits for the select; busy readout is selected at completion
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      seen_select <= 1'b0;
    end else if (!in_read) begin
      seen_select <= 1'b0;
    end else if (selected) begin
      seen_select <= 1'b1; // R10 R18
    end
  end

  // pin drive: hi-z through conversion, low idle while trigger and select are low
  logic next_oe;
  logic next_data;
  wire idle_low = (state == SAR_ST_IDLE) && !trig_now && !sel_now; // R16
  wire read_drive = in_read && selected && !read_end; // R10 R18 R22
  wire load_busy = in_load && busy_en && buf_out_valid && (mode == SAR_MODE_SELECT);

  always_comb begin
    next_oe = 1'b0;
    next_data = 1'b0;
    if (in_conv || start_conv) begin
      next_oe = 1'b0; // R6 R22
    end else if (load_busy) begin
      next_oe = 1'b1; // R14
    end else if (read_drive) begin
      next_oe = 1'b1;
      next_data = shifter[SH_W-1]; // R12
    end else if (idle_low) begin
      next_oe = 1'b1; // R16
    end
  end

  // bits change a few core cycles after a serial clock fall and then hold
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      serial_result_oe_out <= 1'b0;
      serial_result_out <= 1'b0;
    end else begin
      serial_result_oe_out <= next_oe;
      serial_result_out <= next_data; // R12
    end
  end

  // status outputs
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      readout_mode_out <= SAR_MODE_SELECT;
      busy_enable_out <= 1'b0;
      converting_out <= 1'b0;
      powered_down_out <= 1'b1;
      conversion_done_out <= 1'b0;
    end else begin
      readout_mode_out <= mode;
      busy_enable_out <= busy_en;
      converting_out <= (next_state == SAR_ST_CONV);
      powered_down_out <= (next_state != SAR_ST_CONV); // R9
      conversion_done_out <= conv_done;
    end
  end

endmodule // sar_readout

// *** logic/sar_regs.svh ***
// sar_regs.svh: timing counts, code limits and readout lengths of the converter readout.
// assumes inclusion by its bare name from the design files; definitions only.
`ifndef SAR_REGS_SVH
`define SAR_REGS_SVH

// result width and saturation codes
`define SAR_CODE_W 16
`define SAR_CODE_FULL 16'hFFFF
`define SAR_CODE_ZERO 16'h0000

// conversion window of the internal timer, in ns, and the clock rate in MHz
`define SAR_CONV_MIN_NS 500
`define SAR_CONV_MAX_NS 700
`define SAR_CLK_MHZ 10

// serial clock falling edges that end a readout
`define SAR_FALLS_PLAIN 5'h10
`define SAR_FALLS_BUSY 5'h11

// bit positions in the synchronised pin vector
`define SAR_PIN_TRIG 0
`define SAR_PIN_SEL 1
`define SAR_PIN_SCK 2
`define SAR_PIN_W 3

`endif

// *** logic/sar_pkg.sv ***
// sar_pkg: types shared by the converter readout modules.
// assumes nothing of its surroundings.
package sar_pkg;

  // readout state, gray coded along idle -> convert -> load -> read -> idle
  typedef enum logic [1:0] {
    SAR_ST_IDLE = 2'h0,
    SAR_ST_CONV = 2'h1,
    SAR_ST_LOAD = 2'h3,
    SAR_ST_READ = 2'h2
  } sar_state_t;

  // operating mode chosen at the trigger's rising edge
  typedef enum logic {
    SAR_MODE_CHAIN = 1'b0,
    SAR_MODE_SELECT = 1'b1
  } sar_mode_t;

endpackage

// *** logic/sar_sync.sv ***
// sar_sync: two flip-flop synchroniser, one pair per bit.
// assumes asynchronous inputs and a synchronous active-low reset.
`timescale 1ns/10ps
module sar_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk_in, // sampling clock
  input wire logic resetn_in, // synchronous reset, active low
  input wire logic [WIDTH-1:0] async_in, // levels from pins
  output logic [WIDTH-1:0] sync_out // synchronised levels
);

  logic [WIDTH-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
          meta[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta[i] <= async_in[i];
          sync_out[i] <= meta[i];
        end
      end
    end
  endgenerate

endmodule // sar_sync

// *** logic/sar_buf.sv ***
// sar_buf: small fifo with valid and ready on both sides.
// assumes a single clock and a synchronous active-low reset; DEPTH at least 2.
`timescale 1ns/10ps
module sar_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input wire logic clk_in, // clock
  input wire logic resetn_in, // synchronous reset, active low
  input wire logic in_valid_in, // write request
  output logic in_ready_out, // room for a word
  input wire logic [WIDTH-1:0] in_data_in, // word written
  output logic out_valid_out, // a word is held
  input wire logic out_ready_in, // reader takes the word
  output logic [WIDTH-1:0] out_data_out // oldest word
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;

  wire do_write = in_valid_in && in_ready_out;
  wire do_read = out_valid_out && out_ready_in;
  wire [PW-1:0] next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
  wire [PW-1:0] next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;

  assign in_ready_out = (count != FULL);
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];

  always_ff @(posedge clk_in) begin
    if (do_write) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_write) begin
        wr_ptr <= next_wr_ptr;
      end
      if (do_read) begin
        rd_ptr <= next_rd_ptr;
      end
      if (do_write && !do_read) begin
        count <= count + 1'b1;
      end else if (do_read && !do_write) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // sar_buf

// *** bench/sar_readout_checker.sv ***
// sar_readout_chk: port-level assertions for the converter readout.
// assumes sar_pkg is compiled first; bound to sar_readout below.
`timescale 1ns/10ps
module sar_readout_chk (
  input wire logic clk_in, // clock
  input wire logic resetn_in, // reset, active low
  input wire logic conversion_trigger_in, // trigger pin
  input wire logic serial_select_in, // select pin
  input wire logic serial_clock_in, // serial clock pin
  input wire logic serial_result_out, // data level
  input wire logic serial_result_oe_out, // pin driven
  input wire sar_pkg::sar_mode_t readout_mode_out, // mode
  input wire logic busy_enable_out, // busy bit in use
  input wire logic converting_out, // converting
  input wire logic powered_down_out, // powered down
  input wire logic conversion_done_out // done pulse
);
  import sar_pkg::*;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  chk_power_down: assert property (powered_down_out == !converting_out)
    else $error("power down not inverse of converting");
  chk_conv_window: assert property ($rose(converting_out) |->
    converting_out [*5] ##[1:4] !converting_out) else $error("conversion length");
  chk_hiz_convert: assert property (converting_out && $past(converting_out) |->
    !serial_result_oe_out) else $error("pin driven during conversion");
  chk_done_single: assert property (conversion_done_out |=> !conversion_done_out)
    else $error("done longer than one cycle");
  chk_done_follows: assert property ($fell(converting_out) |-> ##[0:2] conversion_done_out)
    else $error("no done after conversion");
  chk_mode_at_start: assert property ($changed(readout_mode_out) |-> ##[0:1] converting_out)
    else $error("mode changed outside a start");
  chk_busy_start: assert property (conversion_done_out ##1 (busy_enable_out &&
    readout_mode_out == SAR_MODE_SELECT) |-> (serial_result_oe_out && !serial_result_out))
    else $error("busy start bit missing");
  chk_chain_low: assert property (readout_mode_out == SAR_MODE_CHAIN &&
    serial_result_oe_out |-> !serial_result_out) else $error("chain mode drove high");
  chk_deselect_hiz: assert property ((conversion_trigger_in && serial_select_in) [*6] |->
    !serial_result_oe_out) else $error("pin driven while deselected");
  chk_bit_hold: assert property (serial_result_oe_out && $past(serial_result_oe_out) &&
    $changed(serial_result_out) |-> !$past(serial_clock_in, 2)) else $error("bit moved off a fall");
  cover property (conversion_done_out ##1 busy_enable_out);
  cover property (converting_out && readout_mode_out == SAR_MODE_CHAIN);
  cover property ($fell(serial_result_oe_out) && !converting_out);
endmodule // sar_readout_chk

bind sar_readout sar_readout_chk u_chk (.clk_in(clk_in), .resetn_in(resetn_in),
  .conversion_trigger_in(conversion_trigger_in), .serial_select_in(serial_select_in),
  .serial_clock_in(serial_clock_in), .serial_result_out(serial_result_out),
  .serial_result_oe_out(serial_result_oe_out), .readout_mode_out(readout_mode_out),
  .busy_enable_out(busy_enable_out), .converting_out(converting_out),
  .powered_down_out(powered_down_out), .conversion_done_out(conversion_done_out));

// *** bench/sar_host.sv ***
// sar_host: serial host model that starts conversions and clocks results out.
// assumes the bench resolves the result line with a pull-up.
`timescale 1ns/10ps
module sar_host (
  input wire logic clk_in, // bench clock
  input wire logic pin_in, // resolved result line
  output logic trig_out, // conversion trigger
  output logic sel_out, // select line
  output logic sck_out // serial clock, still between frames
);
  initial begin
    trig_out = 1'h0;
    sel_out = 1'h1;
    sck_out = 1'h0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask
  // levels at the rise pick the mode and chain busy
  task automatic start(input logic sel, input logic sck, input logic tied);
    sel_out = sel;
    sck_out = sck;
    step(4);
    trig_out = 1'h1;
    if (tied) sel_out = 1'h1;
    step(6);
    sck_out = 1'h0;
  endtask
  // trigger selects in 3-wire use, select in 4-wire use
  task automatic line(input logic wires4, input logic lvl);
    if (wires4) sel_out = lvl;
    else trig_out = lvl;
  endtask
  // dip back before the minimum time, or stay low to ask for busy
  task automatic dip(input logic wires4, input logic busy);
    line(wires4, 1'h0);
    step(1);
    if (!busy) line(wires4, 1'h1);
  endtask
  // sample just before each fall, so no hold after the fall is needed
  task automatic shift(input int falls, output logic [16:0] word);
    word = 17'h00000;
    #37;
    for (int k = 0; k < falls; k++) begin
      sck_out = 1'h1;
      #400;
      word = {word[15:0], pin_in};
      sck_out = 1'h0;
      #400;
    end
  endtask
  // deselect first so trigger and select are never low together
  task automatic idle();
    sel_out = 1'h1;
    step(14);
    trig_out = 1'h0;
    step(4);
  endtask
endmodule // sar_host

// *** bench/testbench.sv ***
// testbench: runs the readout through the host model in every select variant.
// assumes design, checker and host files are compiled before this one.
`timescale 1ns/10ps
module testbench;
  import sar_pkg::*;
  typedef struct packed {
    logic w4;
    logic busy;
    logic over;
    logic under;
    logic [15:0] code;
    logic [15:0] exp;
  } sar_row_t;
  sar_row_t rows [7] = '{
    '{1'h0, 1'h0, 1'h0, 1'h0, 16'hA5C3, 16'hA5C3},
    '{1'h0, 1'h1, 1'h0, 1'h0, 16'h8001, 16'h8001},
    '{1'h1, 1'h0, 1'h0, 1'h0, 16'h7FFF, 16'h7FFF},
    '{1'h1, 1'h1, 1'h0, 1'h0, 16'h0001, 16'h0001},
    '{1'h0, 1'h0, 1'h1, 1'h0, 16'h1234, 16'hFFFF},
    '{1'h1, 1'h1, 1'h0, 1'h1, 16'hFFFE, 16'h0000},
    '{1'h0, 1'h1, 1'h1, 1'h1, 16'h5555, 16'hFFFF}};
  logic clk_in;
  logic resetn_in;
  logic over;
  logic under;
  logic [15:0] code;
  logic dout, oe, busy_en, conv, pd, done;
  sar_mode_t mode;
  wire trig, sel, sck;
  wire pin = oe ? dout : 1'h1; // pull-up on the result line
  int err_total = 0;
  int num_checks = 0;
  logic [16:0] word;

  sar_readout dut (.clk_in(clk_in), .resetn_in(resetn_in), .conversion_trigger_in(trig),
    .serial_select_in(sel), .serial_clock_in(sck), .sample_code_in(code),
    .over_range_in(over), .under_range_in(under), .serial_result_out(dout),
    .serial_result_oe_out(oe), .readout_mode_out(mode), .busy_enable_out(busy_en),
    .converting_out(conv), .powered_down_out(pd), .conversion_done_out(done));
  sar_host host (.clk_in(clk_in), .pin_in(pin), .trig_out(trig), .sel_out(sel), .sck_out(sck));

  task automatic check(input logic [16:0] seen, input logic [16:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic run_row(input sar_row_t r);
    int n;
    code = r.code;
    over = r.over;
    under = r.under;
    host.start(1'h1, 1'h0, 1'h0);
    host.dip(r.w4, r.busy);
    if (r.busy) begin
      for (n = 0; n < 40 && pin !== 1'h0; n++) host.step(1);
      if (n == 40) begin
        err_total++;
        $display("[ERR] %0t no start bit", $time);
        conclude();
      end
    end else begin
      host.step(10);
      check(oe, 1'h0, "no start bit");
      host.line(r.w4, 1'h0);
      host.step(4);
    end
    check(busy_en, r.busy, "busy flag");
    check({oe, mode}, {1'h1, SAR_MODE_SELECT}, "selected");
    host.shift(r.busy ? 17 : 16, word);
    check(word, {1'h0, r.exp}, "result");
    host.step(6);
    check(oe, 1'h0, "end of frame");
    host.idle();
  endtask

  initial begin
    clk_in = 1'h0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    resetn_in = 1'h0;
    over = 1'h0;
    under = 1'h0;
    code = 16'h0000;
    repeat (4) @(posedge clk_in);
    #2;
    check({oe, busy_en, conv, done, pd}, 5'h01, "reset");
    resetn_in = 1'h1;
    host.idle();
    host.line(1'h1, 1'h0);
    host.step(5);
    check({oe, dout}, 2'h2, "idle low");
    host.idle();
    $display("reset and idle done");
    foreach (rows[i]) begin
      run_row(rows[i]);
      $display("row %0d done", i);
    end
    code = 16'hC3A5;
    over = 1'h0;
    under = 1'h0;
    for (int w = 0; w < 2; w++) begin
      host.start(1'h1, 1'h0, 1'h0);
      host.step(12);
      host.line(w[0], 1'h0);
      host.step(4);
      host.shift(5, word);
      check(word, 17'h00018, "partial");
      host.line(w[0], 1'h1);
      host.step(5);
      check(oe, 1'h0, "abort");
      host.idle();
      $display("abort %0d done", w);
    end
    for (int i = 0; i < 3; i++) begin
      host.start(1'h0, (i == 1), (i == 2));
      check(conv, 1'h1, "converting");
      host.step(12);
      check({mode, busy_en}, {SAR_MODE_CHAIN, (i == 1)}, "chain");
      host.idle();
      $display("chain %0d done", i);
    end
    conclude();
  end
endmodule // testbench
